//--- rsc_pkg.sv
// Purpose: Shared constants and types for the reset sequence controller.
// Assumes: 50 MHz primary oscillator clock; all counts are in clock cycles.
// Notes:   Register offsets are byte addresses of 32-bit words.
package rsc_pkg;

  // Register map.
  localparam int             ADDR_W     = 8;
  localparam logic [7:0]     OFS_CTRL   = 8'h00;
  localparam logic [7:0]     OFS_STAT   = 8'h04;
  localparam logic [7:0]     OFS_COUNTS = 8'h08;
  localparam logic [7:0]     OFS_MODRST = 8'h0c;
  localparam logic [7:0]     OFS_SEQ    = 8'h10;

  // Control register fields.
  localparam int             CTRL_SW_COLD      = 0;
  localparam int             CTRL_SW_WARM      = 1;
  localparam int             CTRL_HS_TRACE_EN  = 4;
  localparam int             CTRL_HS_FABRIC_EN = 5;
  localparam int             CTRL_HS_MEM_EN    = 6;
  localparam int             CTRL_SAFE_DIS     = 8;
  localparam int             CTRL_SAFE_DBG_DIS = 9;
  localparam int             CTRL_BOOT_RAM     = 10;
  localparam int             CTRL_TRACE_HS_CLR = 12;
  localparam logic [31:0]    CTRL_RESET        = 32'h0000_0070;

  // Status register fields (sticky, write one to clear).
  localparam int             STAT_COLD_PIN  = 0;
  localparam int             STAT_COLD_SW   = 1;
  localparam int             STAT_COLD_MOD  = 2;
  localparam int             STAT_WARM_PIN  = 4;
  localparam int             STAT_WARM_SW   = 5;
  localparam int             STAT_WARM_MOD  = 6;
  localparam int             STAT_WARM_WDOG = 7;

  // Counts register fields.
  localparam int             CNT_WARM_LSB = 0;
  localparam int             CNT_WARM_W   = 8;
  localparam int             CNT_PIN_LSB  = 8;
  localparam int             CNT_PIN_W    = 16;
  localparam logic [31:0]    COUNTS_RESET = 32'h0008_0080;

  // Module reset control fields; a one holds the module in reset.
  localparam int             MOD_SEC      = 0;
  localparam int             MOD_PER_LSB  = 8;
  localparam int             MOD_DMA_LSB  = 16;
  localparam int             PER_W        = 8;
  localparam int             DMA_W        = 8;
  localparam logic [31:0]    MODRST_RESET = 32'h00ff_ff01;

  // Sequence timing in cycles.
  localparam logic [15:0]    COLD_CLKMGR_CYC = 16'h0020;
  localparam logic [15:0]    COLD_SETTLE_CYC = 16'h0060;
  localparam logic [15:0]    WARM_SAFE_CYC   = 16'h0008;
  localparam logic [15:0]    PIN_STRETCH_CYC = 16'h0100;
  localparam logic [15:0]    REL_MISC_CYC    = 16'h0064;
  localparam logic [15:0]    REL_CLKOFF_CYC  = 16'h00c8;
  localparam logic [15:0]    REL_MPU_CYC     = 16'h0020;
  localparam logic [15:0]    REL_CLKON_CYC   = 16'h0020;

  // Synchronised input vector layout.
  localparam int             SY_W          = 11;
  localparam int             SY_COLD_PIN_N = 0;
  localparam int             SY_WARM_PIN_N = 1;
  localparam int             SY_MOD_COLD   = 2;
  localparam int             SY_MOD_WARM   = 3;
  localparam int             SY_WDOG       = 4;
  localparam int             SY_ACK_TRACE  = 5;
  localparam int             SY_ACK_FABRIC = 6;
  localparam int             SY_ACK_MEM    = 7;
  localparam int             SY_ACK_SCAN   = 8;
  localparam int             SY_ACK_CFG    = 9;
  localparam int             SY_SAFE_ACK   = 10;
  localparam logic [10:0]    SY_RESET      = 11'h003;

  typedef enum logic [3:0] {
    ST_IDLE, ST_COLD_HOLD, ST_COLD_CLK, ST_COLD_SETTLE,
    ST_HS_TRACE, ST_HS_FABRIC, ST_HS_MEM, ST_WARM_ASSERT, ST_WARM_WAIT,
    ST_REL_L3, ST_REL_MISC, ST_REL_CLKOFF, ST_REL_CLKON
  } rsc_state_type;

endpackage : rsc_pkg

//--- rsc_sync.sv
// Purpose: Two-flop synchroniser for a vector of asynchronous inputs.
// Assumes: Each bit is an independent level; no bus coherence is needed.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ps
module rsc_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rsc_sync_state_type;

  rsc_sync_state_type r;
  rsc_sync_state_type n;

  // Each bit gets its own pair of stages.
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_comb
      begin
        n.s1[g] = async_in[g];
        n.s2[g] = r.s1[g];
      end
    end
  endgenerate

  // Reset to the idle level of each input so no false request appears.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      r <= '{s1: RST_VAL, s2: RST_VAL};
    else
      r <= n;
  end

  assign sync_out = r.s2;

endmodule : rsc_sync

//--- rsc_sequencer.sv
// Purpose: Cold and warm reset sequencer with warm-reset handshakes.
// Assumes: sys_clk is the primary oscillator clock; requests are async.
// Notes:   Module resets are active low; registers on a plain port.
`timescale 1ns/1ps
module rsc_sequencer (
  input  wire logic                     sys_clk,
  input  wire logic                     reset_n,
  input  wire logic [rsc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              reg_rdata,
  input  wire logic                     cold_request_pin,
  input  wire logic                     warm_reset_bidir_pin_in,
  output logic                          warm_reset_bidir_pin_out,
  output logic                          warm_reset_bidir_pin_oe,
  input  wire logic                     mod_cold_req,
  input  wire logic                     mod_warm_req,
  input  wire logic                     wdog_warm_req,
  output logic                          trace_router_hs_req,
  input  wire logic                     trace_router_hs_ack,
  output logic                          fabric_hs_req,
  input  wire logic                     fabric_hs_ack,
  output logic                          mem_hs_req,
  input  wire logic                     mem_hs_ack,
  output logic                          scan_hs_req,
  input  wire logic                     scan_hs_ack,
  output logic                          cfg_hs_req,
  input  wire logic                     cfg_hs_ack,
  output logic                          safe_mode_req,
  input  wire logic                     safe_mode_ack,
  output logic                          safe_dbg_clk_keep,
  output logic                          boot_from_ram,
  output logic                          clkmgr_cold_rst_n,
  output logic                          l3_rst_n,
  output logic                          misc_rst_n,
  output logic                          misc_cold_rst_n,
  output logic                          dbg_rst_n,
  output logic                          primary_core_rst_n,
  output logic                          wdog_rst_n,
  output logic                          core_clk_off,
  output logic                          secondary_core_rst_n,
  output logic      [rsc_pkg::PER_W-1:0] periph_rst_n,
  output logic      [rsc_pkg::DMA_W-1:0] dma_if_reset_ctrl
);
  import rsc_pkg::*;

  typedef struct packed {
    rsc_state_type fsm;
    logic [15:0]   cnt;
    logic [15:0]   pin_cnt;
    logic          pin_stretch;
    logic          pin_done;
    logic [2:0]    pin_dly;
    logic          cold_seq;
    logic          wdog_only;
    logic          warm_pend;
    logic          warm_any_d;
    logic [31:0]   ctrl;
    logic [31:0]   stat;
    logic [31:0]   counts;
    logic [31:0]   modrst_n;
    logic [31:0]   rdata;
    logic          pin_out;
    logic          pin_oe;
    logic          pin_oe_n;
    logic          hs_trace;
    logic          hs_fabric;
    logic          hs_group;
    logic          safe_req;
    logic          clkmgr_n;
    logic          l3_n;
    logic          misc_n;
    logic          misc_cold_n;
    logic          dbg_n;
    logic          mpu_n;
    logic          wdog_n;
    logic          clk_off;
  } rsc_top_state_type;

  // Power-on is a cold reset: every module reset starts asserted.
  localparam rsc_top_state_type RESET_STATE = '{
    fsm: ST_COLD_HOLD, ctrl: CTRL_RESET, counts: COUNTS_RESET,
    cold_seq: 1'b1, pin_oe: 1'b1, modrst_n: ~MODRST_RESET, default: '0};

  rsc_top_state_type r;
  rsc_top_state_type n;
  logic [SY_W-1:0]   sy;

  // Pins, module requests and acknowledges all cross into sys_clk here.
  rsc_sync #(
    .W       (SY_W),
    .RST_VAL (SY_RESET)
  ) u_sync (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .async_in ({safe_mode_ack, cfg_hs_ack, scan_hs_ack, mem_hs_ack, fabric_hs_ack,
                trace_router_hs_ack, wdog_warm_req, mod_warm_req, mod_cold_req,
                warm_reset_bidir_pin_in, cold_request_pin}),
    .sync_out (sy)
  );

  logic        cold_pin;
  logic        warm_pin_raw;
  logic        warm_pin;
  logic        cold_any;
  logic        warm_any;
  logic        wdog_alone;
  logic        wr_ctrl;
  logic        pin_zero;
  logic        pin_ok;
  logic        safe_ok;
  logic        warm_ok;
  logic [15:0] pin_len;
  logic [15:0] warm_len;

  // Request decode. The warm pin is masked while we drive it, plus the
  // synchroniser delay, so the sequencer never retriggers itself.
  always_comb
  begin
    wr_ctrl      = reg_wr && (reg_addr == OFS_CTRL);
    cold_pin     = ~sy[SY_COLD_PIN_N];
    warm_pin_raw = ~sy[SY_WARM_PIN_N];
    warm_pin     = warm_pin_raw && !r.pin_oe && (r.pin_dly == 3'h0);
    cold_any     = cold_pin || r.ctrl[CTRL_SW_COLD] || sy[SY_MOD_COLD];
    warm_any     = warm_pin || r.ctrl[CTRL_SW_WARM] || sy[SY_MOD_WARM] || sy[SY_WDOG];
    wdog_alone   = sy[SY_WDOG] && !(warm_pin || r.ctrl[CTRL_SW_WARM] || sy[SY_MOD_WARM]);
    pin_len      = r.counts[CNT_PIN_LSB +: CNT_PIN_W];
    warm_len     = {8'h00, r.counts[CNT_WARM_LSB +: CNT_WARM_W]};
    pin_zero     = (pin_len == 16'h0000);
    pin_ok       = pin_zero ? !warm_pin_raw : r.pin_done;
    safe_ok      = r.ctrl[CTRL_SAFE_DIS] || sy[SY_SAFE_ACK];
    warm_ok      = (r.cnt >= warm_len);
  end

  // Next-state logic: register port, status, pin timer and the sequencer.
  always_comb
  begin
    n = r;
    n.warm_any_d = warm_any;
    n.pin_dly = {r.pin_dly[1:0], r.pin_oe};
    n.pin_out = 1'b0;

    // Read data stand in the cycle after the strobe only.
    n.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_CTRL:   n.rdata = r.ctrl;
        OFS_STAT:   n.rdata = r.stat;
        OFS_COUNTS: n.rdata = r.counts;
        OFS_MODRST: n.rdata = ~r.modrst_n;
        OFS_SEQ:    n.rdata = {20'h00000, r.safe_req, r.hs_group, r.hs_fabric,
                               r.hs_trace, r.pin_oe, r.cold_seq, r.warm_pend,
                               r.wdog_only, r.fsm};
        default:    n.rdata = 32'h0000_0000;
      endcase
    end

    // Software request bits are one-cycle pulses.
    n.ctrl[CTRL_SW_COLD]      = 1'b0;
    n.ctrl[CTRL_SW_WARM]      = 1'b0;
    n.ctrl[CTRL_TRACE_HS_CLR] = 1'b0;
    if (wr_ctrl)
      n.ctrl = reg_wdata;
    if (wr_ctrl && reg_wdata[CTRL_TRACE_HS_CLR])
      n.hs_trace = 1'b0;
    if (reg_wr && (reg_addr == OFS_COUNTS))
      n.counts = reg_wdata;
    if (reg_wr && (reg_addr == OFS_MODRST))
      n.modrst_n = ~reg_wdata;

    // Sticky status: a new event wins over a clear in the same cycle.
    if (reg_wr && (reg_addr == OFS_STAT))
      n.stat = r.stat & ~reg_wdata;
    n.stat[STAT_COLD_PIN]  = n.stat[STAT_COLD_PIN]  | cold_pin;
    n.stat[STAT_COLD_SW]   = n.stat[STAT_COLD_SW]   | r.ctrl[CTRL_SW_COLD];
    n.stat[STAT_COLD_MOD]  = n.stat[STAT_COLD_MOD]  | sy[SY_MOD_COLD];
    n.stat[STAT_WARM_PIN]  = n.stat[STAT_WARM_PIN]  | warm_pin;
    n.stat[STAT_WARM_SW]   = n.stat[STAT_WARM_SW]   | r.ctrl[CTRL_SW_WARM];
    n.stat[STAT_WARM_MOD]  = n.stat[STAT_WARM_MOD]  | sy[SY_MOD_WARM];
    n.stat[STAT_WARM_WDOG] = n.stat[STAT_WARM_WDOG] | sy[SY_WDOG];

    // Warm pin timer: low for the pin count, then a fixed stretch.
    if (r.pin_oe)
    begin
      n.pin_cnt = r.pin_cnt + 16'h0001;
      if (r.pin_cnt >= pin_len - 16'h0001)
      begin
        n.pin_oe      = 1'b0;
        n.pin_cnt     = 16'h0000;
        n.pin_stretch = 1'b1;
      end
    end
    else if (r.pin_stretch)
    begin
      n.pin_cnt = r.pin_cnt + 16'h0001;
      if (r.pin_cnt == PIN_STRETCH_CYC - 16'h0001)
      begin
        n.pin_stretch = 1'b0;
        n.pin_done    = 1'b1;
      end
    end

    n.cnt = r.cnt + 16'h0001;
    if (cold_any && (r.fsm != ST_COLD_HOLD))
    begin
      // Cold preempts everything, including a release in progress.
      n.fsm         = ST_COLD_HOLD;
      n.cold_seq    = 1'b1;
      n.warm_pend   = 1'b0;
      n.ctrl        = CTRL_RESET;
      n.modrst_n    = ~MODRST_RESET;
      n.clkmgr_n    = 1'b0;
      n.l3_n        = 1'b0;
      n.misc_n      = 1'b0;
      n.misc_cold_n = 1'b0;
      n.dbg_n       = 1'b0;
      n.mpu_n       = 1'b0;
      n.wdog_n      = 1'b0;
      n.clk_off     = 1'b0;
      n.hs_trace    = 1'b0;
      n.hs_fabric   = 1'b0;
      n.hs_group    = 1'b0;
      n.safe_req    = 1'b0;
      n.pin_oe      = 1'b0;
      n.pin_stretch = 1'b0;
    end
    else
    begin
      // A new warm edge from ST_HS_TRACE on is queued; in ST_WARM_WAIT it also restarts the wait.
      if ((r.fsm >= ST_HS_TRACE) && warm_any && !r.warm_any_d)
      begin
        n.warm_pend = 1'b1;
        if (r.fsm == ST_WARM_WAIT)
          n.cnt = 16'h0000;
      end
      case (r.fsm)
        ST_IDLE:
        begin
          if (warm_any || r.warm_pend)
          begin
            n.fsm       = ST_HS_TRACE;
            n.cold_seq  = 1'b0;
            n.warm_pend = 1'b0;
            n.wdog_only = wdog_alone;
          end
        end
        ST_COLD_HOLD:
        begin
          // The pin is pulled low only while reset_n is held; a cold reset never stretches it.
          n.cnt         = 16'h0000;
          n.pin_oe      = 1'b0;
          n.pin_stretch = 1'b0;
          if (!cold_any)
            n.fsm = ST_COLD_CLK;
        end
        ST_COLD_CLK:
        begin
          if (r.cnt == COLD_CLKMGR_CYC - 16'h0001)
          begin
            n.clkmgr_n = 1'b1;
            n.fsm      = ST_COLD_SETTLE;
            n.cnt      = 16'h0000;
          end
        end
        ST_COLD_SETTLE:
        begin
          if (r.cnt == COLD_SETTLE_CYC - 16'h0001)
          begin
            n.l3_n = 1'b1;
            n.fsm  = ST_REL_L3;
            n.cnt  = 16'h0000;
          end
        end
        ST_HS_TRACE:
        begin
          n.hs_trace = r.ctrl[CTRL_HS_TRACE_EN];
          if (!r.ctrl[CTRL_HS_TRACE_EN] || sy[SY_ACK_TRACE])
            n.fsm = ST_HS_FABRIC;
        end
        ST_HS_FABRIC:
        begin
          n.hs_fabric = r.ctrl[CTRL_HS_FABRIC_EN];
          if (!r.ctrl[CTRL_HS_FABRIC_EN] || sy[SY_ACK_FABRIC])
            n.fsm = ST_HS_MEM;
        end
        ST_HS_MEM:
        begin
          n.hs_group = r.ctrl[CTRL_HS_MEM_EN];
          if (!r.ctrl[CTRL_HS_MEM_EN] ||
              (sy[SY_ACK_MEM] && sy[SY_ACK_SCAN] && sy[SY_ACK_CFG]))
          begin
            // Debug and cold-only resets are left untouched.
            n.fsm       = ST_WARM_ASSERT;
            n.cnt       = 16'h0000;
            n.l3_n      = 1'b0;
            n.misc_n    = 1'b0;
            n.mpu_n     = 1'b0;
            n.wdog_n    = r.wdog_only;
            n.modrst_n  = ~MODRST_RESET;
            n.pin_oe    = !pin_zero;
            n.pin_cnt   = 16'h0000;
            n.pin_done  = 1'b0;
            n.pin_stretch = 1'b0;
          end
        end
        ST_WARM_ASSERT:
        begin
          if (r.cnt == WARM_SAFE_CYC - 16'h0001)
          begin
            n.safe_req = !r.ctrl[CTRL_SAFE_DIS];
            n.fsm      = ST_WARM_WAIT;
            n.cnt      = 16'h0000;
          end
        end
        ST_WARM_WAIT:
        begin
          // Hold the counter once it has met its length, but keep a queued restart.
          if (warm_ok && (n.cnt != 16'h0000))
            n.cnt = r.cnt;
          if (warm_ok && pin_ok && safe_ok && n.cnt != 16'h0000)
          begin
            // The trace handshake stays up until software clears it.
            n.hs_fabric = 1'b0;
            n.hs_group  = 1'b0;
            n.safe_req  = 1'b0;
            n.l3_n      = 1'b1;
            n.fsm       = ST_REL_L3;
            n.cnt       = 16'h0000;
          end
        end
        ST_REL_L3:
        begin
          if (r.cnt == REL_MISC_CYC - 16'h0001)
          begin
            n.misc_n      = 1'b1;
            n.misc_cold_n = r.cold_seq ? 1'b1 : r.misc_cold_n;
            n.dbg_n       = r.cold_seq ? 1'b1 : r.dbg_n;
            n.fsm         = ST_REL_MISC;
            n.cnt         = 16'h0000;
          end
        end
        ST_REL_MISC:
        begin
          if (r.cnt == REL_CLKOFF_CYC - 16'h0001)
          begin
            n.clk_off = 1'b1;
            n.fsm     = ST_REL_CLKOFF;
            n.cnt     = 16'h0000;
          end
        end
        ST_REL_CLKOFF:
        begin
          if (r.cnt == REL_MPU_CYC - 16'h0001)
          begin
            // Only the primary core group; the secondary core stays held.
            n.mpu_n  = 1'b1;
            n.wdog_n = 1'b1;
            n.fsm    = ST_REL_CLKON;
            n.cnt    = 16'h0000;
          end
        end
        ST_REL_CLKON:
        begin
          if (r.cnt == REL_CLKON_CYC - 16'h0001)
          begin
            n.clk_off = 1'b0;
            n.fsm     = ST_IDLE;
            n.cnt     = 16'h0000;
          end
        end
        default:
        begin
          n.fsm = ST_COLD_HOLD;
        end
      endcase
    end
    // The pin enable is kept inverted in its own flop so the port needs no gate.
    n.pin_oe_n = !n.pin_oe;
  end

  // Reset asserts every module reset at once; release is clocked only.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      r <= RESET_STATE;
    else
      r <= n;
  end

  // Outputs come straight from the state register. Config bits are only
  // reset by cold reset, so warm reset leaves them in place.
  assign reg_rdata                = r.rdata;
  assign warm_reset_bidir_pin_out = r.pin_out;
  assign warm_reset_bidir_pin_oe  = r.pin_oe_n;
  assign trace_router_hs_req      = r.hs_trace;
  assign fabric_hs_req            = r.hs_fabric;
  assign mem_hs_req               = r.hs_group;
  assign scan_hs_req              = r.hs_group;
  assign cfg_hs_req               = r.hs_group;
  assign safe_mode_req            = r.safe_req;
  assign safe_dbg_clk_keep        = r.ctrl[CTRL_SAFE_DBG_DIS];
  assign boot_from_ram            = r.ctrl[CTRL_BOOT_RAM];
  assign clkmgr_cold_rst_n        = r.clkmgr_n;
  assign l3_rst_n                 = r.l3_n;
  assign misc_rst_n               = r.misc_n;
  assign misc_cold_rst_n          = r.misc_cold_n;
  assign dbg_rst_n                = r.dbg_n;
  assign primary_core_rst_n       = r.mpu_n;
  assign wdog_rst_n               = r.wdog_n;
  assign core_clk_off             = r.clk_off;
  assign secondary_core_rst_n     = r.modrst_n[MOD_SEC];
  assign periph_rst_n             = r.modrst_n[MOD_PER_LSB +: PER_W];
  assign dma_if_reset_ctrl        = r.modrst_n[MOD_DMA_LSB +: DMA_W];

endmodule : rsc_sequencer

//--- rsc_sequencer_props.sv
// Purpose: Timing checks on the sequencer's reset outputs.
// Assumes: One clock domain; reset_n clears all state.
// Notes:   Windows allow one cycle of slack around each count.
`timescale 1ns/1ps
module rsc_sequencer_props (
  input wire logic             sys_clk,
  input wire logic             reset_n,
  input wire logic             cold_request_pin,
  input wire logic             clkmgr_cold_rst_n,
  input wire logic             l3_rst_n,
  input wire logic             misc_rst_n,
  input wire logic             primary_core_rst_n,
  input wire logic             core_clk_off,
  input wire logic             safe_mode_req,
  input wire logic             secondary_core_rst_n,
  input wire logic [7:0]       periph_rst_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // A cold request that stays up keeps the interconnect in reset.
  cold_hold_a : assert property (!cold_request_pin [*5] |-> !l3_rst_n)
    else $error("cold request not held");
  clk_settle_a : assert property ($rose(clkmgr_cold_rst_n) |-> ##[95:97] $rose(l3_rst_n))
    else $error("settle time wrong");
  // A new cold request may cut this step short, which is legal.
  misc_after_a : assert property ($rose(l3_rst_n) |->
    ##[99:101] ($rose(misc_rst_n) || !l3_rst_n))
    else $error("misc release late");
  clk_off_a : assert property ($rose(misc_rst_n) |-> ##[199:201] $rose(core_clk_off))
    else $error("core clock gate late");
  core_rel_a : assert property ($rose(core_clk_off) |-> ##[31:33] $rose(primary_core_rst_n))
    else $error("core release late");
  clk_on_a : assert property ($rose(primary_core_rst_n) |-> ##[31:33] $fell(core_clk_off))
    else $error("core clock ungate late");
  held_after_a : assert property ($rose(primary_core_rst_n) |->
    !secondary_core_rst_n && periph_rst_n == 8'h00)
    else $error("held resets released");
  safe_req_a : assert property ($fell(l3_rst_n) && clkmgr_cold_rst_n |->
    ##[7:9] $rose(safe_mode_req))
    else $error("safe mode request late");
endmodule : rsc_sequencer_props

bind rsc_sequencer rsc_sequencer_props rsc_sequencer_props_i (.*);

//--- rsc_partner.sv
// Purpose: Warm handshake and safe-mode partners of the sequencer.
// Assumes: Each partner acknowledges by following its request level.
// Notes:   DLY sets how slowly the partners answer.
`timescale 1ns/1ps
module rsc_partner #(
  parameter int DLY = 3
) (
  input  wire logic       sys_clk,
  input  wire logic [5:0] req,
  output logic      [5:0] ack
);
  logic [5:0] pipe_r [DLY];
  // Acks trail requests on both edges, so a stuck request is never hidden.
  always_ff @(posedge sys_clk)
  begin
    pipe_r[0] <= req;
    for (int i = 1; i < DLY; i++)
      pipe_r[i] <= pipe_r[i-1];
  end
  assign ack = pipe_r[DLY-1];
endmodule : rsc_partner

//--- test_reset_sequence_controller.sv
// Purpose: Self-checking bench for the reset sequencer.
// Assumes: Partners answer three cycles late; of the module requests only the watchdog one is pulsed.
// Notes:   The warm pin has a pull-up and a push-button driver.
`timescale 1ns/1ps
module test_reset_sequence_controller;
  import rsc_pkg::*;
  logic sys_clk, reset_n, reg_wr, reg_rd, cold_request_pin, ext_warm_n;
  logic mod_cold_req, mod_warm_req, wdog_warm_req, warm_reset_bidir_pin_out;
  logic [7:0] reg_addr, periph_rst_n, dma_if_reset_ctrl;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic warm_reset_bidir_pin_oe, trace_router_hs_req, fabric_hs_req, mem_hs_req, scan_hs_req;
  logic cfg_hs_req, safe_mode_req, safe_dbg_clk_keep, boot_from_ram, clkmgr_cold_rst_n;
  logic l3_rst_n, misc_rst_n, misc_cold_rst_n, dbg_rst_n, primary_core_rst_n, wdog_rst_n;
  logic core_clk_off, secondary_core_rst_n;
  wire  trace_router_hs_ack, fabric_hs_ack, mem_hs_ack, scan_hs_ack, cfg_hs_ack, safe_mode_ack;
  int   bad_count = 0, n_tests = 0, low_n = 0, dbg_low = 0, wd_low = 0;
  // Open drain: the pin is low whenever anyone pulls it, else pulled up.
  wire  warm_reset_bidir_pin_in = warm_reset_bidir_pin_oe ? ext_warm_n : 1'b0;
  rsc_sequencer rsc_sequencer_i (.*);
  rsc_partner rsc_partner_i (.sys_clk(sys_clk), .req({safe_mode_req, cfg_hs_req, scan_hs_req,
    mem_hs_req, fabric_hs_req, trace_router_hs_req}), .ack({safe_mode_ack, cfg_hs_ack,
    scan_hs_ack, mem_hs_ack, fabric_hs_ack, trace_router_hs_ack}));
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Counts cycles of pin drive and of debug reset.
  always @(posedge sys_clk)
  begin
    low_n += !warm_reset_bidir_pin_oe;
    dbg_low += !dbg_rst_n;
    wd_low += !wdog_rst_n;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  // Waits for the core to enter reset and then for the full release.
  task settle;
    int i;
    for (i = 0; i < 200 && primary_core_rst_n; i++) @(posedge sys_clk);
    for (i = 0; i < 3000 && !(primary_core_rst_n && !core_clk_off); i++) @(posedge sys_clk);
    chk(i < 3000, 1);
  endtask : settle
  task t_cold_start;
    settle();
    chk({secondary_core_rst_n, periph_rst_n, misc_cold_rst_n}, 10'h001);
    rd(OFS_CTRL, CTRL_RESET);
    rd(OFS_COUNTS, COUNTS_RESET);
    rd(OFS_MODRST, MODRST_RESET);
    rd(8'h40, 32'h0);
    $display("cold start test done");
  endtask : t_cold_start
  task t_cold_again;
    int i;
    cold_request_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    cold_request_pin <= 1'b1;
    for (i = 0; i < 300 && !l3_rst_n; i++) @(posedge sys_clk);
    cold_request_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk(l3_rst_n, 0);
    cold_request_pin <= 1'b1;
    settle();
    rd(OFS_STAT, 32'h1 << STAT_COLD_PIN);
    wr(OFS_STAT, 32'hffff_ffff);
    rd(OFS_STAT, 32'h0);
    $display("cold restart test done");
  endtask : t_cold_again
  task t_warm;
    wr(OFS_COUNTS, 32'h0000_1010);
    low_n = 0;
    dbg_low = 0;
    wr(OFS_CTRL, CTRL_RESET | 32'h1 << CTRL_BOOT_RAM | 32'h1 << CTRL_SW_WARM);
    settle();
    chk(low_n, 16);
    chk(dbg_low, 0);
    chk({boot_from_ram, trace_router_hs_req, fabric_hs_req}, 3'b110);
    chk({mem_hs_req, scan_hs_req, cfg_hs_req, safe_mode_req}, 4'h0);
    rd(OFS_STAT, 32'h1 << STAT_WARM_SW);
    wr(OFS_CTRL, CTRL_RESET | 32'h1 << CTRL_TRACE_HS_CLR);
    @(posedge sys_clk);
    chk(trace_router_hs_req, 0);
    $display("warm test done");
  endtask : t_warm
  // Watchdog alone, zero pin count: pin never driven, watchdog reset spared.
  task t_warm_wdog;
    wr(OFS_COUNTS, 32'h0000_0010);
    low_n = 0;
    wd_low = 0;
    wdog_warm_req <= 1'b1;
    repeat (8) @(posedge sys_clk);
    wdog_warm_req <= 1'b0;
    settle();
    chk(low_n, 0);
    chk(wd_low, 0);
    rd(OFS_STAT, 32'h1 << STAT_WARM_SW | 32'h1 << STAT_WARM_WDOG);
    $display("watchdog warm test done");
  endtask : t_warm_wdog
  // Software frees the secondary core first, then the peripherals.
  task t_modrst;
    wr(OFS_MODRST, MODRST_RESET & ~32'h1);
    @(posedge sys_clk);
    chk({secondary_core_rst_n, periph_rst_n}, 9'h100);
    wr(OFS_CTRL, CTRL_RESET | 32'h1 << CTRL_SAFE_DBG_DIS);
    wr(OFS_MODRST, 32'h0);
    @(posedge sys_clk);
    chk({safe_dbg_clk_keep, periph_rst_n, dma_if_reset_ctrl}, 17'h1ffff);
    chk(warm_reset_bidir_pin_out, 0);
    rd(OFS_MODRST, 32'h0);
    $display("module reset test done");
  endtask : t_modrst
  task final_report;
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial
  begin
    {reset_n, reg_wr, reg_rd, mod_cold_req, mod_warm_req, wdog_warm_req} = '0;
    {cold_request_pin, ext_warm_n, reg_addr, reg_wdata} = {2'b11, 40'h0};
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_cold_start();
    t_cold_again();
    t_warm();
    t_warm_wdog();
    t_modrst();
    final_report();
  end
  // The whole run needs under 2500 cycles; allow eight times that.
  initial
  begin
    #400000;
    bad_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    final_report();
  end
endmodule : test_reset_sequence_controller
